// ==== verilog/ulsf_pkg.sv ====
// Package for the receive line status flag block
package ulsf_pkg;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
    // Register byte addresses
    localparam logic [7:0] ADDR_RX_DATA = 8'h00;
    localparam logic [7:0] ADDR_LINE_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
    // Line status bit positions
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_PE = 2;
    localparam int LS_FE = 3;
    localparam int LS_FSUM = 7;
    // Control bits
    localparam int CTL_FIFO_EN = 0;
    localparam int CTL_PAR_EN = 1;
    localparam int CTL_PAR_EVEN = 2;
    localparam logic [2:0] CTL_RESET = 3'h0;
    // Interrupt status bits
    localparam int IRQ_W = 4;
    localparam int IRQ_DR = 0;
    localparam int IRQ_OE = 1;
    localparam int IRQ_PE = 2;
    localparam int IRQ_FE = 3;

    // Character delivered by the receive deserialiser
    typedef struct packed {
        logic [7:0] data;
        logic parity_bit;
        logic stop_ok;
    } ulsf_char_t;

    // Character stored with its error tags
    typedef struct packed {
        logic [7:0] data;
        logic par_err;
        logic frm_err;
    } ulsf_entry_t;
endpackage : ulsf_pkg

// ==== verilog/ulsf_rx_status.sv ====
// Receive line status flags with receive FIFO and APB register slave
// Functional notes
// - Framing error is set when a character lacks a valid stop bit.
// - Parity error in line status bit 2 flags a character of bad parity.
// - In FIFO mode parity and framing flags follow the FIFO head.
// - Overrun in bit 1 is set when a character completes on a full FIFO.
// - On overrun the new character overwrites the shift register.
// - On overrun the shift register byte is not pushed into the FIFO.
// - Data ready in bit 0 is 1 while a character is held.
// - Data ready is 0 when nothing is held, also after reset.
// - Overrun and parity flags reset to 0 and set only on an error.
// - Framing error sits in bit 3 and resets to 0.
// - Bit 7 is set in FIFO mode while any held character has an error.
`timescale 1ns/100ps
module ulsf_rx_status
    import ulsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ulsf_char_t rx_char,
    input wire logic rx_char_valid,
    output logic [7:0] rx_shift_data,
    output logic irq
);
    function automatic logic par_bad(input ulsf_char_t c,
                                     input logic even);
        par_bad = ((^c.data) ^ c.parity_bit) != ~even;
    endfunction : par_bad

    ulsf_entry_t fifo_reg [FIFO_DEPTH];
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    ulsf_entry_t hold_reg;
    logic hold_valid_reg;
    logic overrun_reg;
    logic [2:0] control_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_enable_reg;
    logic [7:0] shift_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;

    logic fifo_mode;
    logic acc;
    logic rd_acc;
    logic wr_acc;
    logic pop;
    logic full;
    logic push;
    logic overrun_evt;
    ulsf_entry_t new_entry;
    ulsf_entry_t head;
    logic data_ready;
    logic fsum;
    logic [7:0] line_status;
    logic [IRQ_W-1:0] irq_events;
    logic fifo_pop;
    logic sel_rx_data;
    logic sel_line_status;
    logic sel_control;
    logic sel_irq_enable;
    logic sel_irq_clear;
    logic [PTR_W-1:0] rd_ptr_next;
    logic [PTR_W-1:0] wr_ptr_next;
    logic [CNT_W-1:0] count_next;
    logic hold_valid_next;
    logic overrun_next;
    logic [IRQ_W-1:0] irq_status_next;
    logic [31:0] read_word;
    logic read_bad;

    assign fifo_mode = control_reg[CTL_FIFO_EN];
    // Access taken on its first edge, answered the cycle after
    assign acc = psel && penable && !pready_reg;
    assign rd_acc = acc && !pwrite;
    assign wr_acc = acc && pwrite;

    // Register address decodes
    assign sel_rx_data = paddr == ADDR_RX_DATA;
    assign sel_line_status = paddr == ADDR_LINE_STATUS;
    assign sel_control = paddr == ADDR_CONTROL;
    assign sel_irq_enable = paddr == ADDR_IRQ_ENABLE;
    assign sel_irq_clear = paddr == ADDR_IRQ_CLEAR;
    assign pop = rd_acc && sel_rx_data;
    // Pop only with a character present
    assign fifo_pop = pop && count_reg != '0;

    always_comb begin
        new_entry.data = rx_char.data;
        new_entry.frm_err = !rx_char.stop_ok;
        new_entry.par_err = control_reg[CTL_PAR_EN]
            && par_bad(rx_char, control_reg[CTL_PAR_EVEN]);
    end

    assign full = fifo_mode ? (count_reg == CNT_FULL) : hold_valid_reg;
    // Freed slot in the same cycle does not rescue the character
    assign overrun_evt = rx_char_valid && full;
    assign push = rx_char_valid && !full;
    assign head = fifo_mode ? fifo_reg[rd_ptr_reg] : hold_reg;
    assign data_ready = fifo_mode ? (count_reg != '0)
                                  : hold_valid_reg;

    always_comb begin
        fsum = 1'b0;
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            if (CNT_W'(i) < count_reg) begin
                if (fifo_reg[rd_ptr_reg + PTR_W'(i)].par_err
                    || fifo_reg[rd_ptr_reg + PTR_W'(i)].frm_err) begin
                    fsum = 1'b1;
                end
            end
        end
        fsum = fsum && fifo_mode;
    end

    always_comb begin
        line_status = '0;
        line_status[LS_DR] = data_ready;
        line_status[LS_OE] = overrun_reg;
        line_status[LS_PE] = data_ready && head.par_err;
        line_status[LS_FE] = data_ready && head.frm_err;
        line_status[LS_FSUM] = fsum;
    end

    // Shift register always keeps the latest character
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shift_reg <= '0;
        end else if (rx_char_valid) begin
            shift_reg <= rx_char.data;
        end
    end

    // FIFO pointers and fill count; leaving FIFO mode flushes
    always_comb begin
        rd_ptr_next = rd_ptr_reg;
        wr_ptr_next = wr_ptr_reg;
        count_next = count_reg;
        if (!fifo_mode) begin
            rd_ptr_next = '0;
            wr_ptr_next = '0;
            count_next = '0;
        end else begin
            if (push) begin
                wr_ptr_next = wr_ptr_reg + PTR_ONE;
            end
            if (fifo_pop) begin
                rd_ptr_next = rd_ptr_reg + PTR_ONE;
            end
            if (push && !fifo_pop) begin
                count_next = count_reg + CNT_ONE;
            end else if (!push && fifo_pop) begin
                count_next = count_reg - CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            rd_ptr_reg <= rd_ptr_next;
            wr_ptr_reg <= wr_ptr_next;
            count_reg <= count_next;
        end
    end

    // Storage has no reset; only counted slots feed the status flags, an RX data read returns the head slot data even when empty, without a pop
    always_ff @(posedge clk_sys) begin
        if (fifo_mode && push) begin
            fifo_reg[wr_ptr_reg] <= new_entry;
        end
    end

    // Holding register for non-FIFO mode
    always_comb begin
        hold_valid_next = hold_valid_reg;
        if (fifo_mode) begin
            hold_valid_next = 1'b0;
        end else if (push) begin
            hold_valid_next = 1'b1;
        end else if (pop) begin
            hold_valid_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_valid_reg <= 1'b0;
        end else begin
            hold_valid_reg <= hold_valid_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_reg <= '0;
        end else if (!fifo_mode && push) begin
            hold_reg <= new_entry;
        end
    end

    // Overrun flag, set wins over read clear
    always_comb begin
        overrun_next = overrun_reg;
        if (overrun_evt) begin
            overrun_next = 1'b1;
        end else if (rd_acc && sel_line_status) begin
            overrun_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overrun_reg <= 1'b0;
        end else begin
            overrun_reg <= overrun_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            control_reg <= CTL_RESET;
        end else if (wr_acc && sel_control) begin
            control_reg <= pwdata[2:0];
        end
    end

    always_comb begin
        irq_events = '0;
        irq_events[IRQ_DR] = push;
        irq_events[IRQ_OE] = overrun_evt;
        irq_events[IRQ_PE] = push && new_entry.par_err;
        irq_events[IRQ_FE] = push && new_entry.frm_err;
    end

    // Sticky interrupt status, new event wins over clear
    always_comb begin
        irq_status_next = irq_status_reg | irq_events;
        if (wr_acc && sel_irq_clear) begin
            irq_status_next = (irq_status_reg & ~pwdata[IRQ_W-1:0])
                              | irq_events;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_enable_reg <= '0;
        end else if (wr_acc && sel_irq_enable) begin
            irq_enable_reg <= pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // Read mux, unmapped addresses refused with an error
    always_comb begin
        read_word = '0;
        read_bad = 1'b0;
        unique case (paddr)
            ADDR_RX_DATA: read_word = {24'h000000, head.data};
            ADDR_LINE_STATUS: read_word = {24'h000000, line_status};
            ADDR_CONTROL: read_word = {29'h0, control_reg};
            ADDR_IRQ_STATUS: read_word = {28'h0, irq_status_reg};
            ADDR_IRQ_ENABLE: read_word = {28'h0, irq_enable_reg};
            ADDR_IRQ_CLEAR: read_word = '0;
            default: read_bad = 1'b1;
        endcase
    end

    // APB slave: one wait state, pready for one cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= acc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= acc && read_bad;
        end
    end

    // Read data stands only in the pready cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata_reg <= '0;
        end else if (acc) begin
            prdata_reg <= read_word;
        end else begin
            prdata_reg <= '0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign rx_shift_data = shift_reg;
    assign irq = irq_reg;
endmodule : ulsf_rx_status

// ==== tb/ulsf_rx_status_assertions.sv ====
// Port-level checks for the receive line status block
`timescale 1ns/100ps
module ulsf_rx_status_chk
    import ulsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ulsf_char_t rx_char,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_shift_data,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_acc;
        psel && penable && !pready;
    endsequence
    sequence s_ls_read;
        pready && !pwrite && paddr == ADDR_LINE_STATUS;
    endsequence
    a_ready_after: assert property (s_acc |=> pready)
        else $error("no ready after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready cycle");
    a_err_on_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (psel && penable && !pready
        && paddr > ADDR_IRQ_CLEAR |=> pslverr)
        else $error("unmapped access not refused");
    a_status_width: assert property (s_ls_read |-> prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0)
        else $error("line status unused bits set");
    a_shift_latest: assert property (rx_char_valid |=> rx_shift_data == $past(rx_char.data))
        else $error("shift data not latest char");
    a_shift_hold: assert property (!rx_char_valid |=> $stable(rx_shift_data))
        else $error("shift data changed without char");
endmodule : ulsf_rx_status_chk

bind ulsf_rx_status ulsf_rx_status_chk u_chk (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid),
    .rx_shift_data(rx_shift_data), .irq(irq));

// ==== tb/ulsf_char_src.sv ====
// Character source standing in for the receive deserialiser
`timescale 1ns/100ps
module ulsf_char_src
    import ulsf_pkg::*;
(
    input wire logic clk_sys,
    output ulsf_char_t rx_char,
    output logic rx_char_valid
);
    initial begin
        rx_char = '0;
        rx_char_valid = 1'h0;
    end
    // One pulse, then the bus shows the inverse, not the old char
    task send(input logic [7:0] d, input logic p, input logic s);
        rx_char <= '{d, p, s};
        rx_char_valid <= 1'h1;
        @(posedge clk_sys);
        rx_char_valid <= 1'h0;
        rx_char <= ulsf_char_t'(~{d, p, s});
        @(posedge clk_sys);
    endtask : send
endmodule : ulsf_char_src

// ==== tb/ulsf_rx_status_test.sv ====
// Self-checking bench for the receive line status block
`timescale 1ns/100ps
module ulsf_rx_status_test;
    import ulsf_pkg::*;
    logic clk_sys = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, irq, err, rx_char_valid;
    logic [7:0] paddr = 8'h00, rx_shift_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    ulsf_char_t rx_char;
    int num_errors = 0, checks_done = 0, i;
    always #50 clk_sys = ~clk_sys;
    ulsf_char_src src (.clk_sys(clk_sys), .rx_char(rx_char),
        .rx_char_valid(rx_char_valid));
    ulsf_rx_status uut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_char(rx_char), .rx_char_valid(rx_char_valid),
        .rx_shift_data(rx_shift_data), .irq(irq));
    task final_report;
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            num_errors++;
            final_report();
        end
        @(posedge clk_sys);
    endtask : apb
    task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'h0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'h0;
        @(posedge clk_sys);
        rchk(ADDR_LINE_STATUS, 32'h0, "status reset");
        src.send(8'hA5, 1'h0, 1'h0);
        rchk(ADDR_LINE_STATUS, 32'h09, "framing");
        rchk(ADDR_IRQ_STATUS, 32'h9, "irq status");
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'h1, ADDR_IRQ_ENABLE, 32'hF);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'h1, ADDR_IRQ_CLEAR, 32'hF);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rchk(ADDR_RX_DATA, 32'hA5, "hold data");
        rchk(ADDR_LINE_STATUS, 32'h0, "empty");
        apb(1'h1, ADDR_CONTROL, 32'h6);
        src.send(8'h01, 1'h0, 1'h1);
        rchk(ADDR_LINE_STATUS, 32'h05, "parity");
        src.send(8'h3C, 1'h0, 1'h1);
        chk("shift data", 32'h3C, {24'h0, rx_shift_data});
        rchk(ADDR_LINE_STATUS, 32'h07, "overrun");
        rchk(ADDR_LINE_STATUS, 32'h05, "overrun clear");
        rchk(ADDR_RX_DATA, 32'h01, "kept data");
        apb(1'h1, ADDR_CONTROL, 32'h7);
        src.send(8'h11, 1'h0, 1'h1);
        src.send(8'h22, 1'h0, 1'h0);
        rchk(ADDR_LINE_STATUS, 32'h81, "head good");
        rchk(ADDR_RX_DATA, 32'h11, "pop one");
        rchk(ADDR_LINE_STATUS, 32'h89, "head bad");
        rchk(ADDR_RX_DATA, 32'h22, "pop two");
        rchk(ADDR_LINE_STATUS, 32'h0, "fifo empty");
        for (i = 0; i <= FIFO_DEPTH; i++)
            src.send(i[7:0], ^i[7:0], 1'h1);
        rchk(ADDR_LINE_STATUS, 32'h03, "fifo overrun");
        chk("shift latest", 32'h10, {24'h0, rx_shift_data});
        for (i = 0; i < FIFO_DEPTH; i++)
            rchk(ADDR_RX_DATA, 32'(i), "fifo data");
        rchk(ADDR_LINE_STATUS, 32'h0, "drained");
        apb(1'h0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'h1, ADDR_LINE_STATUS, 32'hFF);
        rchk(ADDR_LINE_STATUS, 32'h0, "read only");
        final_report();
    end
endmodule : ulsf_rx_status_test
